// ### io_level_pkg.sv
// constants and carrier types for the input level and pad bias register bank
// assumes a byte-wide internal register port driven by the serial host interface
// Overview of operation
// - upper level bit 2 reads the live column ten pin, never written.
// - upper level bit 1 reads the live column nine pin, read only.
// - upper level bit 0 reads the live column eight pin, read only.
// - bias code 00 weak up, 01 down, 10 strong up, 11 all off.
// - standard variants reset every bias register with a default to zero.
// - alternate variant resets first row bias register to 0100 0001.
// - alternate variant resets second row bias register to 0000 0001.
// - alternate variant resets second column bias register to 0001 0001.
// - alternate variant resets third column bias register to 0000 0100.
package io_level_pkg;

    localparam int          NUM_PINS          = 19;
    localparam int          NUM_ROWS          = 8;
    localparam int          PINS_PER_REG      = 4;
    localparam int          NUM_BIAS_REGS     = 5;

    localparam logic [7:0]  UPPER_LEVELS_ADDR = 8'h18;
    localparam logic [7:0]  ROW_BIAS_LOW_ADDR = 8'h19;
    localparam logic [7:0]  ROW_BIAS_HIGH_ADDR = 8'h1A;
    localparam logic [7:0]  COL_BIAS_LOW_ADDR = 8'h1B;
    localparam logic [7:0]  COL_BIAS_MID_ADDR = 8'h1C;
    localparam logic [7:0]  COL_BIAS_HIGH_ADDR = 8'h1D;

    localparam int          INPUT17_BIT       = 0;
    localparam int          INPUT18_BIT       = 1;
    localparam int          INPUT19_BIT       = 2;

    localparam logic [1:0]  BIAS_WEAK_UP      = 2'h0;
    localparam logic [1:0]  BIAS_DOWN         = 2'h1;
    localparam logic [1:0]  BIAS_STRONG_UP    = 2'h2;
    localparam logic [1:0]  BIAS_OFF          = 2'h3;

    // standard variant defaults; the column low register has no printed default
    localparam logic [7:0]  STD_ROW_LOW_RST   = 8'h00;
    localparam logic [7:0]  STD_ROW_HIGH_RST  = 8'h00;
    localparam logic [7:0]  STD_COL_LOW_RST   = 8'h00;
    localparam logic [7:0]  STD_COL_MID_RST   = 8'h00;
    localparam logic [7:0]  STD_COL_HIGH_RST  = 8'h00;

    localparam logic [7:0]  ALT_ROW_LOW_RST   = 8'h41;
    localparam logic [7:0]  ALT_ROW_HIGH_RST  = 8'h01;
    localparam logic [7:0]  ALT_COL_LOW_RST   = 8'h00;
    localparam logic [7:0]  ALT_COL_MID_RST   = 8'h11;
    localparam logic [7:0]  ALT_COL_HIGH_RST  = 8'h04;

    localparam logic [1:0]  COL_HIGH_RSVD_MSB = 2'h0;

    typedef struct packed {
        logic weak_up;
        logic pull_down;
        logic strong_up;
    } pad_bias_type;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } reg_req_type;

endpackage

// ### io_level_and_bias_regs.sv
// input level status and per-pin pad bias selector registers
// assumes the host interface presents one register access per cycle, already in
// this clock domain, and that the level pins are synchronous to clock_in
`timescale 1ns/10ps
module io_level_and_bias_regs #(
    parameter bit ALT_VARIANT = 1'b0
) (
    input  wire logic                                       clock_in,
    input  wire logic                                       rst_in,
    input  wire io_level_pkg::reg_req_type                  reg_req_in,
    input  wire logic                                       column_eight_pin_in,
    input  wire logic                                       column_nine_pin_in,
    input  wire logic                                       column_ten_pin_in,
    output logic [7:0]                                      reg_rdata_out,
    output logic                                            reg_rvalid_out,
    output io_level_pkg::pad_bias_type [io_level_pkg::NUM_PINS-1:0] pad_bias_out
);
    import io_level_pkg::*;

    // register slots in address order, the level register first
    localparam int          NUM_SLOTS     = NUM_BIAS_REGS + 1;
    localparam int          SLOT_LEVELS   = 0;
    localparam int          SLOT_ROW_LOW  = 1;
    localparam int          SLOT_ROW_HIGH = 2;
    localparam int          SLOT_COL_LOW  = 3;
    localparam int          SLOT_COL_MID  = 4;
    localparam int          SLOT_COL_HIGH = 5;

    // every selector is two bits wide; the stored image holds only real selectors
    localparam int          BIAS_W        = 2;
    localparam int          IMG_W         = NUM_PINS * BIAS_W;

    // reset byte of one bias register for the chosen ordering variant
    function automatic logic [7:0] reset_byte(input int slot);
        logic [7:0] value;
        value = 8'h00;
        unique case (slot)
            SLOT_ROW_LOW: begin
                value = ALT_VARIANT ? ALT_ROW_LOW_RST : STD_ROW_LOW_RST;
            end
            SLOT_ROW_HIGH: begin
                value = ALT_VARIANT ? ALT_ROW_HIGH_RST : STD_ROW_HIGH_RST;
            end
            SLOT_COL_LOW: begin
                // no printed default here; zero keeps both variants alike
                value = ALT_VARIANT ? ALT_COL_LOW_RST : STD_COL_LOW_RST;
            end
            SLOT_COL_MID: begin
                value = ALT_VARIANT ? ALT_COL_MID_RST : STD_COL_MID_RST;
            end
            SLOT_COL_HIGH: begin
                value = ALT_VARIANT ? ALT_COL_HIGH_RST : STD_COL_HIGH_RST;
            end
            default: begin
                value = 8'h00;
            end
        endcase
        return value;
    endfunction

    // one-hot pad controls for a selector code; code 11 leaves the pad floating
    function automatic pad_bias_type decode_bias(input logic [1:0] code);
        pad_bias_type pads;
        pads = '0;
        unique case (code)
            BIAS_WEAK_UP: begin
                pads.weak_up = 1'b1;
            end
            BIAS_DOWN: begin
                pads.pull_down = 1'b1;
            end
            BIAS_STRONG_UP: begin
                pads.strong_up = 1'b1;
            end
            BIAS_OFF: begin
                pads = '0;
            end
        endcase
        return pads;
    endfunction

    logic [NUM_SLOTS-1:0]   write_hit;
    logic [NUM_SLOTS-1:0]   read_hit;
    logic [IMG_W-1:0]       bias_image;
    logic [7:0]             level_byte;
    logic [7:0]             slot_image [NUM_SLOTS];
    logic [7:0]             rdata_q;
    logic [7:0]             rdata_d;
    logic                   rvalid_q;
    logic                   rvalid_d;

    // address decode; the level register and unmapped places take no write
    always_comb begin
        write_hit = '0;
        read_hit  = '0;
        unique case (reg_req_in.addr)
            UPPER_LEVELS_ADDR: begin
                read_hit[SLOT_LEVELS]    = reg_req_in.rd;
            end
            ROW_BIAS_LOW_ADDR: begin
                write_hit[SLOT_ROW_LOW]  = reg_req_in.wr;
                read_hit[SLOT_ROW_LOW]   = reg_req_in.rd;
            end
            ROW_BIAS_HIGH_ADDR: begin
                write_hit[SLOT_ROW_HIGH] = reg_req_in.wr;
                read_hit[SLOT_ROW_HIGH]  = reg_req_in.rd;
            end
            COL_BIAS_LOW_ADDR: begin
                write_hit[SLOT_COL_LOW]  = reg_req_in.wr;
                read_hit[SLOT_COL_LOW]   = reg_req_in.rd;
            end
            COL_BIAS_MID_ADDR: begin
                write_hit[SLOT_COL_MID]  = reg_req_in.wr;
                read_hit[SLOT_COL_MID]   = reg_req_in.rd;
            end
            COL_BIAS_HIGH_ADDR: begin
                write_hit[SLOT_COL_HIGH] = reg_req_in.wr;
                read_hit[SLOT_COL_HIGH]  = reg_req_in.rd;
            end
            default: begin
                write_hit = '0;
                read_hit  = '0;
            end
        endcase
    end

    // one selector per pin; pin p sits in slot 1 + p/4 at bits 2*(p%4)
    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
        localparam int           PIN_SLOT = SLOT_ROW_LOW + p / PINS_PER_REG;
        localparam int           PIN_LSB  = BIAS_W * (p % PINS_PER_REG);
        localparam logic [7:0]   SLOT_RST = reset_byte(PIN_SLOT);
        localparam logic [1:0]   SEL_RST  = SLOT_RST[PIN_LSB +: BIAS_W];
        localparam pad_bias_type PADS_RST = decode_bias(SEL_RST);

        logic [1:0]              sel_q;
        logic [1:0]              sel_d;
        pad_bias_type            pad_q;
        pad_bias_type            pad_d;

        always_comb begin
            sel_d = sel_q;
            // new selector is taken at the write edge
            if (write_hit[PIN_SLOT]) begin
                sel_d = reg_req_in.wdata[PIN_LSB +: BIAS_W];
            end
            // decoded from the next value so the pads change with the stored code
            pad_d = decode_bias(sel_d);
        end

        always_ff @(posedge clock_in or posedge rst_in) begin
            if (rst_in) begin
                sel_q <= SEL_RST;
                pad_q <= PADS_RST;
            end else begin
                sel_q <= sel_d;
                pad_q <= pad_d;
            end
        end

        assign bias_image[BIAS_W*p +: BIAS_W] = sel_q;
        assign pad_bias_out[p]                = pad_q;
    end

    // live levels, sampled only when a read is taken
    always_comb begin
        level_byte              = 8'h00;
        level_byte[INPUT19_BIT] = column_ten_pin_in;
        level_byte[INPUT18_BIT] = column_nine_pin_in;
        level_byte[INPUT17_BIT] = column_eight_pin_in;
    end

    // what each slot reads back
    always_comb begin
        slot_image[SLOT_LEVELS]   = level_byte;
        slot_image[SLOT_ROW_LOW]  = bias_image[7:0];
        slot_image[SLOT_ROW_HIGH] = bias_image[15:8];
        slot_image[SLOT_COL_LOW]  = bias_image[23:16];
        slot_image[SLOT_COL_MID]  = bias_image[31:24];
        // the two top bits of the last bias register are reserved and read zero
        slot_image[SLOT_COL_HIGH] = {COL_HIGH_RSVD_MSB, bias_image[IMG_W-1:32]};
    end

    // reads only sample state; nothing is cleared or advanced by them
    always_comb begin
        rvalid_d = reg_req_in.rd;
        rdata_d  = rdata_q;
        if (reg_req_in.rd) begin
            // an unmapped read still answers, with zero
            rdata_d = 8'h00;
            for (int s = 0; s < NUM_SLOTS; s++) begin
                if (read_hit[s]) begin
                    rdata_d = slot_image[s];
                end
            end
        end
    end

    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    // both read outputs come straight from their flip-flops
    assign reg_rdata_out  = rdata_q;
    assign reg_rvalid_out = rvalid_q;

endmodule

// ### io_level_monitor.sv
// assertion checker for the level and bias register bank
// bound onto the bank at the foot of this file; sees only its ports
`timescale 1ns/10ps
module io_level_monitor #(
    parameter bit ALT_VARIANT = 1'b0
) (
    input wire logic                              clock_in,
    input wire logic                              rst_in,
    input wire io_level_pkg::reg_req_type         reg_req_in,
    input wire logic                              column_eight_pin_in,
    input wire logic                              column_nine_pin_in,
    input wire logic                              column_ten_pin_in,
    input wire logic [7:0]                        reg_rdata_out,
    input wire logic                              reg_rvalid_out,
    input wire io_level_pkg::pad_bias_type [18:0] pad_bias_out
);
    import io_level_pkg::*;
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    sequence read_of(logic [7:0] a);
        reg_req_in.rd && reg_req_in.addr == a;
    endsequence
    sequence write_of(logic [7:0] a);
        reg_req_in.wr && reg_req_in.addr == a;
    endsequence
    read_answer_a: assert property (reg_req_in.rd |=> reg_rvalid_out)
        else $error("read not answered");
    no_stray_a: assert property (!reg_req_in.rd |=> !reg_rvalid_out)
        else $error("stray read answer");
    level_read_a:
        assert property (read_of(8'h18) |=> reg_rdata_out == {5'h00, $past(column_ten_pin_in),
            $past(column_nine_pin_in), $past(column_eight_pin_in)}) else $error("bad level read");
    reserved_zero_a: assert property (read_of(8'h1D) |=> reg_rdata_out[7:6] == 2'h0)
        else $error("reserved bits set");
    row_decode_a:
        assert property (write_of(8'h19) |=>
            pad_bias_out[0] == 3'h4 >> $past(reg_req_in.wdata[1:0]))
            else $error("row bias decode");
    col_decode_a:
        assert property (write_of(8'h1D) |=>
            pad_bias_out[18] == 3'h4 >> $past(reg_req_in.wdata[5:4]))
            else $error("column bias decode");
    status_ro_a: assert property (write_of(8'h18) |=> $stable(pad_bias_out))
        else $error("status write took effect");
    reset_image_a:
        assert property ($fell(rst_in) |-> pad_bias_out[0] == (ALT_VARIANT ? 3'h2 : 3'h4))
            else $error("bad reset image");
    reset_column_a:
        assert property ($fell(rst_in) |-> pad_bias_out[17] == (ALT_VARIANT ? 3'h2 : 3'h4))
            else $error("bad column reset image");
endmodule
bind io_level_and_bias_regs io_level_monitor #(.ALT_VARIANT(ALT_VARIANT)) mon_u (
    .clock_in(clock_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
    .column_eight_pin_in(column_eight_pin_in), .column_nine_pin_in(column_nine_pin_in),
    .column_ten_pin_in(column_ten_pin_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .pad_bias_out(pad_bias_out));

// ### test_io_level_and_bias_regs.sv
// random self-checking bench for the level and bias register bank, standard variant
// assumes the monitor file is compiled before it and binds itself
`timescale 1ns/10ps
module test_io_level_and_bias_regs;
    import io_level_pkg::*;
    logic                        clock_in = 1'b0;
    logic                        rst_in = 1'b1;
    reg_req_type                 reg_req_in = '0;
    logic [2:0]                  pins = 3'h0;
    logic [7:0]                  reg_rdata_out;
    logic                        reg_rvalid_out;
    pad_bias_type [NUM_PINS-1:0] pad_bias_out;
    pad_bias_type [NUM_PINS-1:0] pad_alt;
    logic [39:0]                 alt_image = {ALT_COL_HIGH_RST, ALT_COL_MID_RST,
        ALT_COL_LOW_RST, ALT_ROW_HIGH_RST, ALT_ROW_LOW_RST};
    logic [7:0]                  model [5];
    logic [7:0]                  notes [$];
    logic [56:0]                 exp_pad;
    int                          n_errors = 0;
    int                          compares = 0;
    io_level_and_bias_regs dut_u (.clock_in(clock_in), .rst_in(rst_in), .reg_req_in(reg_req_in),
        .column_eight_pin_in(pins[0]), .column_nine_pin_in(pins[1]),
        .column_ten_pin_in(pins[2]), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out), .pad_bias_out(pad_bias_out));
    // second copy in the alternate variant, only its reset pads are judged
    io_level_and_bias_regs #(.ALT_VARIANT(1'b1)) dut_alt_u (.clock_in(clock_in),
        .rst_in(rst_in), .reg_req_in(reg_req_in), .column_eight_pin_in(pins[0]),
        .column_nine_pin_in(pins[1]), .column_ten_pin_in(pins[2]), .reg_rdata_out(),
        .reg_rvalid_out(), .pad_bias_out(pad_alt));
    always #5 clock_in = ~clock_in;
    task automatic check(string what, logic [63:0] seen, logic [63:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic summarize;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // oldest note pairs with the oldest answer, since reads are answered in order
    always @(posedge clock_in) begin
        #1;
        if (reg_rvalid_out === 1'b1 && notes.size() == 0) check("stray read", 1, 0);
        else if (reg_rvalid_out === 1'b1)
            check("read data", reg_rdata_out, notes.pop_front());
    end
    initial begin
        logic [7:0] a;
        logic [7:0] d;
        logic [1:0] op;
        void'($urandom(48483));
        foreach (model[i]) model[i] = 8'h00;
        repeat (6) @(negedge clock_in);
        rst_in = 1'b0;
        for (int p = 0; p < NUM_PINS; p++) exp_pad[3*p+:3] = 3'h4 >> alt_image[2*p+:2];
        check("alternate reset pads", pad_alt, exp_pad);
        // addresses span one below and one above the bank to hit unmapped places
        repeat (600) begin
            @(negedge clock_in);
            for (int p = 0; p < NUM_PINS; p++) exp_pad[3*p+:3] = 3'h4 >> model[p/4][2*(p%4)+:2];
            check("pad bias", pad_bias_out, exp_pad);
            op = 2'($urandom);
            a = 8'h17 + 8'($urandom % 8);
            d = 8'($urandom);
            pins = 3'($urandom);
            reg_req_in = '{addr: a, wr: op == 2'h1, rd: op[1], wdata: d};
            if (op[1]) notes.push_back(a == 8'h18 ? {5'h00, pins} :
                (a inside {[8'h19:8'h1D]}) ? model[a - 8'h19] : 8'h00);
            if (op == 2'h1 && a inside {[8'h19:8'h1D]})
                model[a - 8'h19] = a == 8'h1D ? d & 8'h3F : d;
        end
        @(negedge clock_in);
        reg_req_in = '0;
        repeat (3) @(negedge clock_in);
        check("pending reads", notes.size(), 0);
        summarize();
    end
endmodule
